// File: bench/burst_mode_and_protection_supervisor_test.sv
`timescale 1ns/1ps
`include "burst_supervisor_consts.svh"
module burst_mode_and_protection_supervisor_test;
    logic        clk, rst, regWr, regRd, lpCycleDone, burstLevelExceeded, stopThresh, mainsRise;
    logic        brownout, brownin, supplyUv, supplyStart, supplyAt12v, memReadDone, memReadOk;
    logic        overtemp, onTimeMax, overcurrent, mainsReset, mainsOn, switchEnable, burstOn;
    logic        forceSwitchOff, hvRecharge, xcapDischarge, memReadReq;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, rd, v;
    logic [9:0]  optoLevel, optoCurrent;
    logic [7:0]  swingSetpoint, powerOffset, o8;
    int          mismatches, compares, cycles, seed;

    // Design and its far side.
    burst_mode_supervisor i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .optoCurrent(optoCurrent),
        .lpCycleDone(lpCycleDone), .burstLevelExceeded(burstLevelExceeded),
        .stopThresh(stopThresh), .mainsRise(mainsRise), .brownout(brownout), .brownin(brownin),
        .supplyUv(supplyUv), .supplyStart(supplyStart), .supplyAt12v(supplyAt12v),
        .memReadDone(memReadDone), .memReadOk(memReadOk), .overtemp(overtemp),
        .onTimeMax(onTimeMax), .overcurrent(overcurrent), .mainsReset(mainsReset),
        .switchEnable(switchEnable), .burstOn(burstOn), .forceSwitchOff(forceSwitchOff),
        .hvRecharge(hvRecharge), .xcapDischarge(xcapDischarge), .memReadReq(memReadReq),
        .swingSetpoint(swingSetpoint), .powerOffset(powerOffset));
    power_stage_model i_stage (.clk(clk), .rst(rst), .switchEnable(switchEnable),
        .optoLevel(optoLevel), .mainsOn(mainsOn), .optoCurrent(optoCurrent),
        .lpCycleDone(lpCycleDone), .mainsRise(mainsRise));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Reset value of each register other than COUNT; unmapped places read zero.
    function automatic logic [15:0] resetVal(input logic [3:0] a);
        case (a)
            `REG_CTRL:    return {8'h00, `CTRL_RESET};
            `REG_TARGET:  return `TARGET_RESET;
            `REG_EXITDLY: return `EXITDLY_RESET;
            `REG_DCHDLY:  return `DCHDLY_RESET;
            default:      return 16'h0000;
        endcase
    endfunction

    // Selects one single-bit output by number so one wait task serves all of them.
    function automatic logic pick(input int k);
        case (k)
            0:       return burstOn;
            1:       return xcapDischarge;
            2:       return switchEnable;
            3:       return hvRecharge;
            4:       return forceSwitchOff;
            default: return memReadReq;
        endcase
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register port: one-cycle strobes, read data stands in the following cycle only.
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask

    // Bounded waits: the limit counts cycles or status reads.
    task automatic waitSig(input int k, input logic val, input int lim);
        int n = 0;
        while (pick(k) !== val && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        chk({15'h0, pick(k)}, {15'h0, val});
    endtask

    task automatic waitSt(input logic [2:0] st, input int lim);
        int n = 0;
        regRead(`REG_STATUS);
        while (rd[2:0] !== st && n < lim) begin
            regRead(`REG_STATUS);
            n++;
        end
        chk({13'h0, rd[2:0]}, {13'h0, st});
    endtask

    // A hang is cut short here and ends as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            conclude();
        end
    end

    // Main sequence.
    initial begin
        {regAddr, regWdata, regWr, regRd, burstLevelExceeded, stopThresh, brownout} = '0;
        {brownin, supplyUv, supplyStart, supplyAt12v, memReadDone, memReadOk} = '0;
        {overtemp, onTimeMax, overcurrent, mainsReset, mainsOn} = '0;
        optoLevel = 10'h12c;
        rst = 1'b1;
        {mismatches, compares, cycles} = '0;
        seed = 32'h2f04;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 chk({10'h0, switchEnable, burstOn, forceSwitchOff, hvRecharge, xcapDischarge,
                memReadReq}, 16'h0000);
        regWrite(4'hb, 16'hffff);
        for (int a = 0; a < 16; a++) begin
            if (a != 4 && a != 6 && a != 8) begin
                regRead(a[3:0]);
                chk(rd, resetVal(a[3:0]));
            end
        end
        for (int a = 1; a < 4; a++) begin
            v = 16'($random(seed));
            regWrite(a[3:0], v);
            regRead(a[3:0]);
            chk(rd, v);
        end
        regWrite(`REG_TARGET, 16'hffff);
        regWrite(`REG_EXITDLY, 16'h0020);
        regWrite(`REG_DCHDLY, 16'h0040);
        // Start-up: the first parameter read fails, the retry succeeds.
        {supplyAt12v, supplyStart, brownin, mainsOn} <= 4'hf;
        waitSig(5, 1'b1, 100);
        memReadDone <= 1'b1;
        repeat (4) @(posedge clk);
        memReadDone <= 1'b0;
        waitSig(5, 1'b1, 50);
        chk({15'h0, switchEnable}, 16'h0000);
        regRead(`REG_PROT);
        chk(rd & 16'h0001, 16'h0001);
        {memReadDone, memReadOk} <= 2'h3;
        waitSt(burst_supervisor_pkg::ST_RUN, 100);
        regWrite(`REG_PRESET, 16'h0001);
        regRead(`REG_PROT);
        chk(rd, 16'h0000);
        // Maximum on-time cuts the switch but leaves the supervisor running.
        onTimeMax <= 1'b1;
        waitSig(4, 1'b1, 10);
        onTimeMax <= 1'b0;
        waitSt(burst_supervisor_pkg::ST_RUN, 0);
        regRead(`REG_PROT);
        chk(rd & 16'h0004, 16'h0004);
        // Optobias: low current raises the offset and boosts the swing, high current lowers it.
        v = 16'($random(seed));
        optoLevel <= {5'h00, v[4:0]} + 10'h00a;
        repeat (4) @(posedge clk);
        #1 chk({8'h0, swingSetpoint}, {8'h0, `SWING_BOOST});
        o8 = powerOffset;
        repeat (3500) @(posedge clk);
        #1 chk({15'h0, powerOffset > o8}, 16'h0001);
        o8 = powerOffset;
        optoLevel <= 10'h12c;
        repeat (2500) @(posedge clk);
        #1 chk({15'h0, powerOffset < o8}, 16'h0001);
        // Short bursts against a long target keep raising the cycle count.
        regRead(`REG_COUNT);
        v = rd;
        repeat (3) begin
            {optoLevel, stopThresh} <= {10'h032, 1'b0};
            waitSig(0, 1'b1, 20);
            {optoLevel, stopThresh} <= {10'h12c, 1'b1};
            waitSig(0, 1'b0, 20);
        end
        regRead(`REG_COUNT);
        chk({15'h0, rd > v}, 16'h0001);
        v = rd;
        regWrite(`REG_TARGET, 16'h0001);
        {optoLevel, stopThresh} <= {10'h032, 1'b0};
        waitSig(0, 1'b1, 20);
        regRead(`REG_COUNT);
        chk(rd, v);
        {optoLevel, stopThresh, burstLevelExceeded} <= {10'h032, 2'h1};
        waitSig(0, 1'b1, 20);
        waitSig(0, 1'b0, 80);
        {optoLevel, stopThresh, burstLevelExceeded} <= {10'h12c, 2'h2};
        // Mains removal starts the discharge only after the programmed delay.
        mainsOn <= 1'b0;
        repeat (32) @(posedge clk);
        #1 chk({15'h0, xcapDischarge}, 16'h0000);
        waitSig(1, 1'b1, 80);
        mainsOn <= 1'b1;
        waitSig(1, 1'b0, 30);
        // Supply undervoltage and recovery.
        {supplyUv, supplyStart} <= 2'h2;
        waitSt(burst_supervisor_pkg::ST_UVP, 20);
        chk({14'h0, switchEnable, hvRecharge}, 16'h0001);
        {supplyUv, supplyStart} <= 2'h1;
        waitSt(burst_supervisor_pkg::ST_RUN, 50);
        // Persistent overcurrent ends in safe restart; supply is held at start level meanwhile.
        overcurrent <= 1'b1;
        waitSig(4, 1'b1, 10);
        waitSt(burst_supervisor_pkg::ST_PROT, 200);
        {overcurrent, supplyStart} <= 2'h0;
        waitSig(3, 1'b1, 10);
        chk({15'h0, switchEnable}, 16'h0000);
        supplyStart <= 1'b1;
        waitSig(3, 1'b0, 10);
        regRead(`REG_PROT);
        chk(rd & 16'h0008, 16'h0008);
        {supplyUv, supplyStart} <= 2'h2;
        repeat (10) @(posedge clk);
        {supplyUv, supplyStart} <= 2'h1;
        waitSt(burst_supervisor_pkg::ST_RUN, 100);
        // Overtemperature with the latched response survives a supply recycle.
        regWrite(`REG_CTRL, 16'h0004);
        overtemp <= 1'b1;
        waitSt(burst_supervisor_pkg::ST_LATCH, 20);
        chk({15'h0, switchEnable}, 16'h0000);
        overtemp <= 1'b0;
        {supplyUv, supplyStart} <= 2'h2;
        repeat (10) @(posedge clk);
        {supplyUv, supplyStart} <= 2'h1;
        repeat (50) @(posedge clk);
        waitSt(burst_supervisor_pkg::ST_LATCH, 0);
        regRead(`REG_PROT);
        chk(rd & 16'h0002, 16'h0002);
        mainsReset <= 1'b1;
        repeat (4) @(posedge clk);
        mainsReset <= 1'b0;
        waitSt(burst_supervisor_pkg::ST_RUN, 100);
        // Brownout holds switching only when the stop option is set; brownin releases it.
        for (int s = 0; s < 2; s++) begin
            regWrite(`REG_CTRL, {13'h0, 1'b1, s[0], 1'b0});
            {brownin, brownout} <= 2'h1;
            repeat (8) @(posedge clk);
            regRead(`REG_STATUS);
            chk({15'h0, rd[6]}, {15'h0, s[0]});
            brownout <= 1'b0;
            repeat (8) @(posedge clk);
            regRead(`REG_STATUS);
            chk({15'h0, rd[6]}, {15'h0, s[0]});
            brownin <= 1'b1;
            repeat (8) @(posedge clk);
            regRead(`REG_STATUS);
            chk({15'h0, rd[6]}, 16'h0000);
        end
        conclude();
    end
endmodule

// File: bench/power_stage_model.sv
`timescale 1ns/1ps
// Far side: optocoupler current, low-power cycle ends and mains sensing.
module power_stage_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Commands from the design and the bench.
    input  wire logic       switchEnable,
    input  wire logic [9:0] optoLevel,
    input  wire logic       mainsOn,
    // Sensed quantities towards the design.
    output logic [9:0]      optoCurrent,
    output logic            lpCycleDone,
    output logic            mainsRise
);
    logic [2:0] phase_q;

    // A low-power cycle ends every sixteen clocks (one rising edge of lpCycleDone), and only while the stage switches.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q     <= 3'h0;
            lpCycleDone <= 1'b0;
        end else begin
            phase_q <= phase_q + 3'h1;
            if (switchEnable && phase_q == 3'h7) begin
                lpCycleDone <= ~lpCycleDone;
            end
        end
    end

    // The mains reading steps up only while mains is connected; without it the line sits low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mainsRise   <= 1'b0;
            optoCurrent <= 10'h000;
        end else begin
            mainsRise   <= mainsOn && phase_q[1:0] == 2'h0;
            optoCurrent <= optoLevel; // A slow collector node lags by one clock.
        end
    end
endmodule

// File: rtl/burst_mode_supervisor.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "burst_supervisor_consts.svh"
module burst_mode_supervisor #(
    parameter int CW = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdata,
    // Analog front end and power stage events (asynchronous).
    input  wire logic [9:0]  optoCurrent,
    input  wire logic        lpCycleDone,
    input  wire logic        burstLevelExceeded,
    input  wire logic        stopThresh,
    input  wire logic        mainsRise,
    input  wire logic        brownout,
    input  wire logic        brownin,
    input  wire logic        supplyUv,
    input  wire logic        supplyStart,
    input  wire logic        supplyAt12v,
    input  wire logic        memReadDone,
    input  wire logic        memReadOk,
    input  wire logic        overtemp,
    input  wire logic        onTimeMax,
    input  wire logic        overcurrent,
    input  wire logic        mainsReset,
    // Outputs to the power stage.
    output logic             switchEnable,
    output logic             burstOn,
    output logic             forceSwitchOff,
    output logic             hvRecharge,
    output logic             xcapDischarge,
    output logic             memReadReq,
    output logic [7:0]       swingSetpoint,
    output logic [7:0]       powerOffset
);
    // Two-flop synchronisers on every asynchronous input.
    localparam int NS = 15;
    logic [NS-1:0] asyncIn, meta1, sync2;
    logic [9:0]    optoM, optoS;
    assign asyncIn = {lpCycleDone, burstLevelExceeded, stopThresh, mainsRise, brownout,
                      brownin, supplyUv, supplyStart, supplyAt12v, memReadDone, memReadOk,
                      overtemp, onTimeMax, overcurrent, mainsReset};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta1 <= '0;
            sync2 <= '0;
            optoM <= '0;
            optoS <= '0;
        end else begin
            meta1 <= asyncIn;
            sync2 <= meta1;
            optoM <= optoCurrent;
            optoS <= optoM;
        end
    end
    logic sLp, sBurstLvl, sStop, sMains, sBo, sBi, sUv, sStart, s12, sMemDone, sMemOk;
    logic sOtp, sMaxOn, sOcp, sMainsRst;
    assign {sLp, sBurstLvl, sStop, sMains, sBo, sBi, sUv, sStart, s12, sMemDone, sMemOk,
            sOtp, sMaxOn, sOcp, sMainsRst} = sync2;

    // Edge detect on the low-power cycle completion, taken after the synchroniser.
    logic lpPrev_q;
    logic lpEdge;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) lpPrev_q <= 1'b0;
        else lpPrev_q <= sLp;
    end
    assign lpEdge = sLp & ~lpPrev_q;

    // Software registers.
    logic [7:0]    ctrl_q;
    logic [CW-1:0] target_q, exitDly_q, dchDly_q;
    logic [3:0]    protFlags_q;
    logic          protReset;
    assign protReset = regWr && regAddr == `REG_PRESET && regWdata[0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q    <= `CTRL_RESET;
            target_q  <= `TARGET_RESET;
            exitDly_q <= `EXITDLY_RESET;
            dchDly_q  <= `DCHDLY_RESET;
        end else if (regWr) begin
            unique case (regAddr)
                `REG_CTRL:    ctrl_q    <= regWdata[7:0];
                `REG_TARGET:  target_q  <= regWdata;
                `REG_EXITDLY: exitDly_q <= regWdata;
                `REG_DCHDLY:  dchDly_q  <= regWdata;
                default: ;
            endcase
        end
    end

    // Supervisor state machine for start-up and protections.
    burst_supervisor_pkg::supv_state_t supv_q;
    logic [3:0] ocpCnt_q;
    logic       memChecked_q;
    logic       ocpTrip, protTrip;
    assign ocpTrip  = ctrl_q[`CTRL_OCP_PROT_EN] && ocpCnt_q >= `OCP_LIMIT;
    assign protTrip = sOtp || ocpTrip;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supv_q       <= burst_supervisor_pkg::ST_LOAD;
            memChecked_q <= 1'b0;
        end else begin
            unique case (supv_q)
                burst_supervisor_pkg::ST_LOAD: begin
                    if (s12 && sMemDone && sMemOk) begin
                        supv_q       <= burst_supervisor_pkg::ST_RUN;
                        memChecked_q <= 1'b1;
                    end
                end
                burst_supervisor_pkg::ST_RUN: begin
                    if (protTrip) begin
                        supv_q <= ctrl_q[`CTRL_SAFE_RESTART] ?
                            burst_supervisor_pkg::ST_PROT : burst_supervisor_pkg::ST_LATCH;
                    end else if (sUv) begin
                        supv_q <= burst_supervisor_pkg::ST_UVP;
                    end
                end
                burst_supervisor_pkg::ST_UVP: begin
                    if (sStart) supv_q <= burst_supervisor_pkg::ST_RUN;
                end
                burst_supervisor_pkg::ST_PROT: begin
                    if (sUv) supv_q <= burst_supervisor_pkg::ST_UVP;
                end
                burst_supervisor_pkg::ST_LATCH: begin
                    if (sMainsRst) supv_q <= burst_supervisor_pkg::ST_LOAD;
                end
                default: supv_q <= burst_supervisor_pkg::ST_LOAD;
            endcase
        end
    end

    // Consecutive overcurrent cycles; a clean cycle resets the run.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ocpCnt_q <= '0;
        else if (supv_q != burst_supervisor_pkg::ST_RUN) ocpCnt_q <= '0;
        else if (lpEdge) ocpCnt_q <= sOcp ? ocpCnt_q + 4'h1 : 4'h0;
    end

    // Sticky protection flags: the set wins over a protection reset.
    logic [3:0] protSet;
    assign protSet = {ocpTrip, sMaxOn, sOtp,
                      supv_q == burst_supervisor_pkg::ST_LOAD && sMemDone && !sMemOk};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) protFlags_q <= '0;
        else protFlags_q <= (protReset ? 4'h0 : protFlags_q) | protSet;
    end

    // Brownout gating; restart only after brownin.
    logic boHold_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) boHold_q <= 1'b0;
        else if (sBo && ctrl_q[`CTRL_BO_STOP]) boHold_q <= 1'b1;
        else if (sBi) boHold_q <= 1'b0;
    end

    // Converter enable, supply recharge and on-time / overcurrent cut.
    logic running;
    assign running = supv_q == burst_supervisor_pkg::ST_RUN && !boHold_q && !sUv;
    // Protection holds the supply at its start level: recharge only below it.
    logic holdOff;
    assign holdOff = supv_q == burst_supervisor_pkg::ST_PROT ||
                     supv_q == burst_supervisor_pkg::ST_LATCH;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switchEnable   <= 1'b0;
            hvRecharge     <= 1'b0;
            forceSwitchOff <= 1'b0;
            memReadReq     <= 1'b0;
        end else begin
            switchEnable   <= running;
            hvRecharge     <= supv_q == burst_supervisor_pkg::ST_UVP ||
                              holdOff && !sStart;
            forceSwitchOff <= sMaxOn || sOcp;
            memReadReq     <= supv_q == burst_supervisor_pkg::ST_LOAD && s12 &&
                              !memChecked_q;
        end
    end

    // Burst engine: period timer, cycle count and hold state.
    burst_supervisor_pkg::burst_state_t bm_q;
    logic [CW-1:0] period_q, cycles_q, cyclesLatched_q, lpCnt_q, contCnt_q;
    logic belowStart, aboveStop;
    assign belowStart = optoS < `BURST_START_UA;
    assign aboveStop  = sStop;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bm_q            <= burst_supervisor_pkg::BM_OFF;
            period_q        <= '0;
            cycles_q        <= 16'h0001;
            cyclesLatched_q <= 16'h0001;
            lpCnt_q         <= '0;
            contCnt_q       <= '0;
        end else if (!running) begin
            bm_q      <= burst_supervisor_pkg::BM_OFF;
            contCnt_q <= '0;
        end else begin
            if (period_q != '1) period_q <= period_q + 16'h0001;
            unique case (bm_q)
                burst_supervisor_pkg::BM_OFF: begin
                    if (!sBurstLvl) bm_q <= burst_supervisor_pkg::BM_HOLD;
                end
                burst_supervisor_pkg::BM_HOLD: begin
                    if (belowStart) begin
                        bm_q            <= burst_supervisor_pkg::BM_ON;
                        period_q        <= '0;
                        lpCnt_q         <= '0;
                        contCnt_q       <= '0;
                        if (period_q < target_q) begin
                            cycles_q        <= cycles_q + 16'h0001;
                            cyclesLatched_q <= cycles_q + 16'h0001;
                        end else begin
                            cyclesLatched_q <= cycles_q;
                        end
                    end
                end
                burst_supervisor_pkg::BM_ON: begin
                    contCnt_q <= contCnt_q + 16'h0001;
                    if (aboveStop) begin
                        bm_q <= burst_supervisor_pkg::BM_HOLD;
                    end else if (contCnt_q >= exitDly_q && sBurstLvl) begin
                        bm_q <= burst_supervisor_pkg::BM_OFF;
                    end else if (lpEdge) begin
                        lpCnt_q <= lpCnt_q + 16'h0001;
                        if (lpCnt_q + 16'h0001 >= cyclesLatched_q)
                            bm_q <= burst_supervisor_pkg::BM_HOLD;
                    end
                end
                default: bm_q <= burst_supervisor_pkg::BM_OFF;
            endcase
        end
    end
    assign burstOn = bm_q == burst_supervisor_pkg::BM_ON;

    // Optobias offset loop, stepped slowly by a divider enable.
    logic [15:0] stepCnt_q;
    logic        stepEn;
    assign stepEn = stepCnt_q == 16'(`OFFSET_STEP_CYC - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) stepCnt_q <= '0;
        else stepCnt_q <= stepEn ? 16'h0000 : stepCnt_q + 16'h0001;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) powerOffset <= '0;
        else if (stepEn && optoS < `OPTOBIAS_TARGET_UA && powerOffset != 8'hff)
            powerOffset <= powerOffset + 8'h01;
        else if (stepEn && optoS > `OPTOBIAS_TARGET_UA && powerOffset != 8'h00)
            powerOffset <= powerOffset - 8'h01;
    end

    // Swing setpoint grows at once on a falling optocurrent.
    logic [9:0] optoPrev_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            optoPrev_q    <= '0;
            swingSetpoint <= '0;
        end else begin
            optoPrev_q    <= optoS;
            swingSetpoint <= (optoS < optoPrev_q) ? powerOffset + `SWING_BOOST
                                                  : powerOffset;
        end
    end

    // Mains presence and X-capacitor discharge timer.
    logic [CW-1:0] mainsIdle_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mainsIdle_q   <= '0;
            xcapDischarge <= 1'b0;
        end else if (sMains) begin
            mainsIdle_q   <= '0;
            xcapDischarge <= 1'b0;
        end else begin
            if (mainsIdle_q != '1) mainsIdle_q <= mainsIdle_q + 16'h0001;
            if (mainsIdle_q >= dchDly_q) xcapDischarge <= 1'b1;
        end
    end

    // Read data, one cycle after the strobe; zero elsewhere.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) regRdata <= '0;
        else if (regRd) begin
            unique case (regAddr)
                `REG_CTRL:    regRdata <= {8'h00, ctrl_q};
                `REG_TARGET:  regRdata <= target_q;
                `REG_EXITDLY: regRdata <= exitDly_q;
                `REG_DCHDLY:  regRdata <= dchDly_q;
                `REG_STATUS:  regRdata <= {8'h00, xcapDischarge, boHold_q, bm_q, 1'b0, supv_q};
                `REG_PROT:    regRdata <= {12'h000, protFlags_q};
                `REG_COUNT:   regRdata <= cyclesLatched_q;
                `REG_OFFSET:  regRdata <= {8'h00, powerOffset};
                default:      regRdata <= '0;
            endcase
        end else regRdata <= '0;
    end

    // Checks.
    property p_xcap_clear;
        @(posedge clk) disable iff (rst) sMains |=> !xcapDischarge;
    endproperty
    a_xcap_clear: assert property (p_xcap_clear) else $error("discharge during mains");

    property p_noswitch_prot;
        @(posedge clk) disable iff (rst)
            supv_q == burst_supervisor_pkg::ST_LATCH |=> !switchEnable;
    endproperty
    a_noswitch_prot: assert property (p_noswitch_prot) else $error("switching latched");

    property p_recharge;
        @(posedge clk) disable iff (rst)
            supv_q == burst_supervisor_pkg::ST_PROT && !sStart |=> hvRecharge;
    endproperty
    a_recharge: assert property (p_recharge) else $error("no recharge in protection");

    property p_recharge_off;
        @(posedge clk) disable iff (rst) holdOff && sStart |=> !hvRecharge;
    endproperty
    a_recharge_off: assert property (p_recharge_off) else $error("recharge at start");

    property p_sticky;
        @(posedge clk) disable iff (rst) protFlags_q[`PF_OTP] && !protReset |=> protFlags_q[`PF_OTP];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_stop;
        @(posedge clk) disable iff (rst) burstOn && running && sStop |=> !burstOn;
    endproperty
    a_stop: assert property (p_stop) else $error("burst not stopped");

    property p_count_end;
        @(posedge clk) disable iff (rst)
            burstOn && lpEdge && lpCnt_q + 16'h0001 >= cyclesLatched_q |=> !burstOn;
    endproperty
    a_count_end: assert property (p_count_end) else $error("burst overran count");

    property p_reuse;
        @(posedge clk) disable iff (rst)
            running && bm_q == burst_supervisor_pkg::BM_HOLD && belowStart &&
            period_q >= target_q |=> cyclesLatched_q == $past(cycles_q);
    endproperty
    a_reuse: assert property (p_reuse) else $error("count not reused");

    property p_fixed;
        @(posedge clk) disable iff (rst) burstOn |=> $stable(cyclesLatched_q);
    endproperty
    a_fixed: assert property (p_fixed) else $error("count moved in burst");

    property p_uvp;
        @(posedge clk) disable iff (rst) sUv |=> !switchEnable;
    endproperty
    a_uvp: assert property (p_uvp) else $error("switching at undervoltage");

    property p_memoff;
        @(posedge clk) disable iff (rst)
            supv_q == burst_supervisor_pkg::ST_LOAD |=> !switchEnable;
    endproperty
    a_memoff: assert property (p_memoff) else $error("switching before load");

    property p_cut;
        @(posedge clk) disable iff (rst) sMaxOn |=> forceSwitchOff && protFlags_q[`PF_MAXON];
    endproperty
    a_cut: assert property (p_cut) else $error("on-time not cut");
endmodule

// File: rtl/burst_supervisor_consts.svh
`ifndef BURST_SUPERVISOR_CONSTS_SVH
`define BURST_SUPERVISOR_CONSTS_SVH
// Threshold codes of the feedback current converter, one count per microamp; feedback target in mV and resistor in kohm.
`define BURST_START_UA     10'd100
`define OPTOBIAS_TARGET_UA 10'd80
`define FB_TARGET_MV       960
`define FB_RES_KOHM        12
// Register offsets.
`define REG_CTRL    4'h0
`define REG_TARGET  4'h1
`define REG_EXITDLY 4'h2
`define REG_DCHDLY  4'h3
`define REG_STATUS  4'h4
`define REG_PROT    4'h5
`define REG_COUNT   4'h6
`define REG_OFFSET  4'h7
`define REG_PRESET  4'h8
// Control field positions.
`define CTRL_SAFE_RESTART 0
`define CTRL_BO_STOP      1
`define CTRL_OCP_PROT_EN  2
// Protection flag positions.
`define PF_MEMFAIL 0
`define PF_OTP     1
`define PF_MAXON   2
`define PF_OCP     3
// Reset values and timing.
`define CTRL_RESET     8'h05
`define TARGET_RESET   16'h0800
`define EXITDLY_RESET  16'h0400
`define DCHDLY_RESET   16'h1000
`define OCP_LIMIT      4'h4
`define OFFSET_STEP_US 10
`define CLK_MHZ        100
`define OFFSET_STEP_CYC ((`OFFSET_STEP_US) * (`CLK_MHZ))
`define SWING_BOOST    8'h10
`endif

// File: rtl/burst_supervisor_pkg.sv
package burst_supervisor_pkg;
    typedef enum logic [2:0] {ST_LOAD, ST_RUN, ST_UVP, ST_PROT, ST_LATCH} supv_state_t;
    typedef enum logic [1:0] {BM_OFF, BM_ON, BM_HOLD} burst_state_t;
endpackage
